//--- verilog/vctg_regs.svh
// Register map, field positions, reset values and sizes of the sequencer
`ifndef VCTG_REGS_SVH
`define VCTG_REGS_SVH

// ****************************************
// Sizes
// ****************************************
`define VCTG_NUM_OUT 24
`define VCTG_NUM_PAT 4
`define VCTG_NUM_REGION 9
`define VCTG_TOG_WORDS 384

// ****************************************
// Byte addresses (paddr[11:0])
// ****************************************
`define VCTG_TOG_BASE 1'b0
`define VCTG_SEQ_BASE 3'b100
`define VCTG_FLD_BASE 3'b101
`define VCTG_CTRL_ADDR 12'hC00
`define VCTG_MODE_ADDR 12'hC04
`define VCTG_STAT_ADDR 12'hC08

// ****************************************
// Word indices inside one sequence
// ****************************************
`define VCTG_SQ_PATSEL 5'h00
`define VCTG_SQ_CTRL 5'h01
`define VCTG_SQ_START 5'h02
`define VCTG_SQ_LEN 5'h06
`define VCTG_SQ_REPA 5'h0A
`define VCTG_SQ_REPEO 5'h0E
`define VCTG_SQ_LINELEN 5'h0F
`define VCTG_SQ_POL 5'h10
`define VCTG_SQ_GSEL0 5'h11
`define VCTG_SQ_GSEL1 5'h12
`define VCTG_SQ_GATE 5'h13
`define VCTG_SQ_FRZ 5'h14
`define VCTG_SQ_WORDS 5'h18

// ****************************************
// Word indices inside one field
// ****************************************
`define VCTG_FD_CFG 4'h0
`define VCTG_FD_LINES 4'h1
`define VCTG_FD_REGION 4'h2
`define VCTG_FD_WORDS 4'hB

// ****************************************
// Field positions
// ****************************************
`define VCTG_F_POS 12:0
`define VCTG_F_HI_POS 28:16
`define VCTG_F_LEN_LO 13:0
`define VCTG_F_LEN_HI 29:16
`define VCTG_F_HOLD 3:0
`define VCTG_F_CONCAT 7:4
`define VCTG_F_REPMODE_A 9:8
`define VCTG_F_REPMODE_B 11:10
`define VCTG_F_PAIRSEL 12
`define VCTG_F_MASK_EVEN 19:16
`define VCTG_F_MASK_ODD 23:20
`define VCTG_F_RCOUNT 3:0
`define VCTG_F_RSEQ 16
`define VCTG_F_MODE_LAST 1:0
`define VCTG_F_MODE_FLD 5:2
`define VCTG_F_RUN 0

// ****************************************
// Reset values
// ****************************************
`define VCTG_CTRL_RST 1'b0
`define VCTG_MODE_RST 32'h0000_0000
`define VCTG_WORD_RST 32'h0000_0000

`endif

//--- verilog/vctg_pkg.sv
// Types shared by the vertical timing sequencer
`default_nettype none
package vctg_pkg;
  typedef enum logic [0:0] {
    VCTG_IDLE = 1'b0,
    VCTG_RUN = 1'b1
  } vctg_state_e;
  typedef logic [12:0] vctg_pos_t;
  typedef logic [13:0] vctg_len_t;
endpackage : vctg_pkg
`default_nettype wire

//--- verilog/vctg_sequencer.sv
// Vertical transfer clock sequencer with APB register access
//
// What this block does
// - toggle positions are 13-bit, 0 to 8191
// - four toggle positions per vertical output
// - transition at group start plus toggle
// - output starts at programmed start polarity
// - pattern length spaces the repetitions
// - gate outputs use one selected toggle pair
// - four group pattern selectors per sequence
// - group A repeat counts, shared even/odd counts for B-D
// - own start position per group
// - even/odd masks enable freeze/resume pairs
// - line length per sequence, max 8192
// - last field line uses final length
// - field has up to nine regions
// - mode list plays fields in order
// - hold bit per group replaces freeze
// - merge mode combines toggles on group A
// - alternation code 0: first/even counts
// - code 1: two-line alternation
// - code 2: three-line cycle
// - code 3: four counts, two-line for B-D
// - two-bit group select per output
// - separate 14-bit even/odd line lengths
`timescale 1ns/1ps
`default_nettype none
`include "vctg_regs.svh"

module vctg_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [23:0] vertical_transfer_outputs,
  output logic line_sync_n
);

  // ****************************************
  // Functions
  // ****************************************

  // Flat toggle word index from pattern, output and toggle number
  function automatic logic [8:0] tog_idx(input logic [1:0] p,
                                         input logic [4:0] o,
                                         input logic [1:0] k);
    tog_idx = 9'(p) * 9'd96 + 9'(o) * 9'd4 + 9'(k);
  endfunction : tog_idx

  // ****************************************
  // Storage
  // ****************************************
  vctg_pkg::vctg_pos_t tog_mem [0:`VCTG_TOG_WORDS-1];
  logic [31:0] seq_mem [0:63];
  logic [31:0] fld_mem [0:31];
  logic run;
  logic [31:0] mode_reg;

  // ****************************************
  // Timing state
  // ****************************************
  vctg_pkg::vctg_state_e state;
  vctg_pkg::vctg_state_e next_state;
  vctg_pkg::vctg_pos_t pix;
  vctg_pkg::vctg_pos_t next_pix;
  vctg_pkg::vctg_pos_t line;
  vctg_pkg::vctg_pos_t next_line;
  logic [1:0] ment;
  logic [1:0] next_ment;
  logic [1:0] lmod3;
  logic [1:0] next_lmod3;
  logic [1:0] lmod4;
  logic [1:0] next_lmod4;
  vctg_pkg::vctg_pos_t g_pos [0:3];
  vctg_pkg::vctg_pos_t next_pos [0:3];
  vctg_pkg::vctg_pos_t g_rep [0:3];
  vctg_pkg::vctg_pos_t next_rep [0:3];
  logic [3:0] g_act;
  logic [3:0] next_act;
  logic [23:0] next_out;

  // ****************************************
  // APB decode
  // ****************************************
  logic acc;
  logic wr;
  logic tog_hit;
  logic seq_hit;
  logic fld_hit;
  logic ctrl_hit;
  logic mode_hit;
  logic stat_hit;
  logic hit;
  logic [5:0] seq_a;
  logic [4:0] fld_a;
  logic [31:0] status;
  logic [31:0] rd_word;

  // Address match per register block
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign seq_a = {paddr[7], paddr[6:2]};
  assign fld_a = {paddr[6], paddr[5:2]};
  assign tog_hit = (paddr[11] == `VCTG_TOG_BASE) &
                   (paddr[10:2] < 9'(`VCTG_TOG_WORDS));
  assign seq_hit = (paddr[11:9] == `VCTG_SEQ_BASE) & ~paddr[8] &
                   (paddr[6:2] < `VCTG_SQ_WORDS);
  assign fld_hit = (paddr[11:9] == `VCTG_FLD_BASE) & (paddr[8:7] == 2'h0) &
                   (paddr[5:2] < `VCTG_FD_WORDS);
  assign ctrl_hit = paddr == `VCTG_CTRL_ADDR;
  assign mode_hit = paddr == `VCTG_MODE_ADDR;
  assign stat_hit = paddr == `VCTG_STAT_ADDR;
  assign hit = tog_hit | seq_hit | fld_hit | ctrl_hit | mode_hit | stat_hit;

  // Read data selection
  assign rd_word = tog_hit ? {19'h00000, tog_mem[paddr[10:2]]} :
                   seq_hit ? seq_mem[seq_a] :
                   fld_hit ? fld_mem[fld_a] :
                   ctrl_hit ? {31'h00000000, run} :
                   mode_hit ? mode_reg :
                   stat_hit ? status : 32'h00000000;

  // ****************************************
  // APB slave response
  // ****************************************

  // One wait-free access phase, response registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (~hit | (pwrite & stat_hit));
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h00000000 : rd_word;
      end
    end
  end

  // Toggle memory has no reset, contents unknown until written
  always_ff @(posedge pclk) begin
    if (wr & tog_hit) begin
      tog_mem[paddr[10:2]] <= pwdata[`VCTG_F_POS];
    end
  end

  // Sequence, field, control and mode words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) begin
        seq_mem[i] <= `VCTG_WORD_RST;
      end
      for (int i = 0; i < 32; i++) begin
        fld_mem[i] <= `VCTG_WORD_RST;
      end
      run <= `VCTG_CTRL_RST;
      mode_reg <= `VCTG_MODE_RST;
    end else if (wr) begin
      if (seq_hit) begin
        seq_mem[seq_a] <= pwdata;
      end
      if (fld_hit) begin
        fld_mem[fld_a] <= pwdata;
      end
      if (ctrl_hit) begin
        run <= pwdata[`VCTG_F_RUN];
      end
      if (mode_hit) begin
        mode_reg <= pwdata;
      end
    end
  end

  // ****************************************
  // Field, region and sequence selection
  // ****************************************
  logic cur_fld;
  logic cur_seq;
  logic [3:0] fld_map;
  logic [31:0] fd_cfg;
  vctg_pkg::vctg_pos_t fd_lines;

  // Mode list picks the field, field picks the region
  assign fld_map = mode_reg[`VCTG_F_MODE_FLD];
  assign cur_fld = fld_map[ment];
  assign fd_cfg = fld_mem[{cur_fld, `VCTG_FD_CFG}];
  assign fd_lines = fld_mem[{cur_fld, `VCTG_FD_LINES}][`VCTG_F_POS];

  // Last region whose start line has been reached wins
  always_comb begin
    logic [31:0] rw;
    rw = fld_mem[{cur_fld, `VCTG_FD_REGION}];
    cur_seq = rw[`VCTG_F_RSEQ];
    for (int r = 1; r < `VCTG_NUM_REGION; r++) begin
      rw = fld_mem[{cur_fld, 4'(r + 2)}];
      if ((4'(r) < fd_cfg[`VCTG_F_RCOUNT]) &&
          (line >= rw[`VCTG_F_POS])) begin
        cur_seq = rw[`VCTG_F_RSEQ];
      end
    end
  end

  // ****************************************
  // Active sequence words
  // ****************************************
  logic [31:0] sq_patsel;
  logic [31:0] sq_ctrl;
  logic [31:0] sq_repeo;
  logic [31:0] sq_linelen;
  logic [23:0] sq_pol;
  logic [47:0] sq_gsel;
  logic [23:0] sq_gate;
  logic odd_line;
  logic last_line;
  vctg_pkg::vctg_len_t cur_len;
  logic line_end;
  logic field_end;
  logic concat;

  // Words of the sequence for the current region
  assign sq_patsel = seq_mem[{cur_seq, `VCTG_SQ_PATSEL}];
  assign sq_ctrl = seq_mem[{cur_seq, `VCTG_SQ_CTRL}];
  assign sq_repeo = seq_mem[{cur_seq, `VCTG_SQ_REPEO}];
  assign sq_linelen = seq_mem[{cur_seq, `VCTG_SQ_LINELEN}];
  assign sq_pol = seq_mem[{cur_seq, `VCTG_SQ_POL}][23:0];
  assign sq_gsel = {seq_mem[{cur_seq, `VCTG_SQ_GSEL1}][23:0],
                    seq_mem[{cur_seq, `VCTG_SQ_GSEL0}][23:0]};
  assign sq_gate = seq_mem[{cur_seq, `VCTG_SQ_GATE}][23:0];
  assign concat = sq_ctrl[`VCTG_F_CONCAT] == 4'h1;

  // Line length: even/odd per sequence, final line per field
  assign odd_line = lmod4[0];
  assign last_line = line == fd_lines - 13'h0001;
  assign cur_len = last_line ? fd_cfg[`VCTG_F_LEN_HI] :
                   odd_line ? sq_linelen[`VCTG_F_LEN_HI] :
                   sq_linelen[`VCTG_F_LEN_LO];
  assign line_end = {1'b0, pix} == cur_len - 14'h0001;
  assign field_end = line_end & last_line;

  // ****************************************
  // Per-group settings
  // ****************************************
  vctg_pkg::vctg_pos_t g_start [0:3];
  vctg_pkg::vctg_pos_t g_len [0:3];
  vctg_pkg::vctg_pos_t g_tgt [0:3];
  logic in_mask;
  logic [3:0] frz;
  logic [3:0] hld;

  // Start, length and repeat count of each group
  always_comb begin
    logic [12:0] ra [0:3];
    logic [12:0] r_ev;
    logic [12:0] r_od;
    ra = '{default: 13'h0000};
    r_ev = sq_repeo[`VCTG_F_POS];
    r_od = sq_repeo[`VCTG_F_HI_POS];
    for (int g = 0; g < 4; g++) begin
      g_start[g] = seq_mem[{cur_seq, `VCTG_SQ_START + 5'(g)}][`VCTG_F_POS];
      g_len[g] = seq_mem[{cur_seq, `VCTG_SQ_LEN + 5'(g)}][`VCTG_F_POS];
      ra[g] = seq_mem[{cur_seq, `VCTG_SQ_REPA + 5'(g)}][`VCTG_F_POS];
    end
    unique case (sq_ctrl[`VCTG_F_REPMODE_A])
      2'h0: g_tgt[0] = ra[0];
      2'h1: g_tgt[0] = odd_line ? ra[1] : ra[0];
      2'h2: g_tgt[0] = ra[lmod3];
      2'h3: g_tgt[0] = ra[lmod4];
    endcase
    for (int g = 1; g < 4; g++) begin
      unique case (sq_ctrl[`VCTG_F_REPMODE_B])
        2'h0: g_tgt[g] = r_ev;
        2'h2: g_tgt[g] = (lmod3 == 2'h0) ? r_ev : r_od;
        default: g_tgt[g] = odd_line ? r_od : r_ev;
      endcase
    end
  end

  // Freeze/resume window enabled by the even or odd mask
  always_comb begin
    logic [3:0] en;
    logic [31:0] fw;
    fw = 32'h00000000;
    en = odd_line ? sq_ctrl[`VCTG_F_MASK_ODD] : sq_ctrl[`VCTG_F_MASK_EVEN];
    in_mask = 1'b0;
    for (int k = 0; k < 4; k++) begin
      fw = seq_mem[{cur_seq, `VCTG_SQ_FRZ + 5'(k)}];
      if (en[k] && pix >= fw[`VCTG_F_POS] && pix < fw[`VCTG_F_HI_POS]) begin
        in_mask = 1'b1;
      end
    end
  end

  // Hold bit turns the freeze into a level hold
  assign frz = {4{in_mask}} & ~sq_ctrl[`VCTG_F_HOLD];
  assign hld = {4{in_mask}} & sq_ctrl[`VCTG_F_HOLD];

  // ****************************************
  // Line and field counting
  // ****************************************

  // Pixel, line, field entry and alternation counters
  always_comb begin
    next_state = run ? vctg_pkg::VCTG_RUN : vctg_pkg::VCTG_IDLE;
    next_pix = pix + 13'h0001;
    next_line = line;
    next_ment = ment;
    next_lmod3 = lmod3;
    next_lmod4 = lmod4;
    if (state == vctg_pkg::VCTG_IDLE) begin
      next_pix = 13'h0000;
      next_line = 13'h0000;
      next_ment = 2'h0;
      next_lmod3 = 2'h0;
      next_lmod4 = 2'h0;
    end else if (line_end) begin
      next_pix = 13'h0000;
      next_line = line + 13'h0001;
      next_lmod3 = (lmod3 == 2'h2) ? 2'h0 : lmod3 + 2'h1;
      next_lmod4 = lmod4 + 2'h1;
      if (field_end) begin
        next_line = 13'h0000;
        next_lmod3 = 2'h0;
        next_lmod4 = 2'h0;
        next_ment = (ment == mode_reg[`VCTG_F_MODE_LAST]) ? 2'h0 :
                    ment + 2'h1;
      end
    end
  end

  // Group engines: start, pattern position, repetition count
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      next_pos[g] = g_pos[g];
      next_rep[g] = g_rep[g];
      next_act[g] = g_act[g];
      if (state == vctg_pkg::VCTG_IDLE || line_end) begin
        next_act[g] = 1'b0;
      end else if (pix == g_start[g] && g_tgt[g] != 13'h0000) begin
        next_act[g] = 1'b1;
        next_pos[g] = 13'h0000;
        next_rep[g] = 13'h0000;
      end else if (g_act[g] && !frz[g]) begin
        if (g_pos[g] == g_len[g] - 13'h0001) begin
          next_pos[g] = 13'h0000;
          next_rep[g] = g_rep[g] + 13'h0001;
          next_act[g] = g_rep[g] != g_tgt[g] - 13'h0001;
        end else begin
          next_pos[g] = g_pos[g] + 13'h0001;
        end
      end
    end
  end

  // Registered timing state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= vctg_pkg::VCTG_IDLE;
      pix <= 13'h0000;
      line <= 13'h0000;
      ment <= 2'h0;
      lmod3 <= 2'h0;
      lmod4 <= 2'h0;
      g_act <= 4'h0;
      for (int g = 0; g < 4; g++) begin
        g_pos[g] <= 13'h0000;
        g_rep[g] <= 13'h0000;
      end
    end else begin
      state <= next_state;
      pix <= next_pix;
      line <= next_line;
      ment <= next_ment;
      lmod3 <= next_lmod3;
      lmod4 <= next_lmod4;
      g_act <= next_act;
      for (int g = 0; g < 4; g++) begin
        g_pos[g] <= next_pos[g];
        g_rep[g] <= next_rep[g];
      end
    end
  end

  assign status = {13'h0000, state == vctg_pkg::VCTG_RUN, ment, cur_fld,
                   2'h0, line};

  // ****************************************
  // Output levels
  // ****************************************

  // Start polarity inverted once per reached toggle
  always_comb begin
    logic [1:0] g;
    logic [1:0] p;
    logic par;
    logic k_on;
    vctg_pkg::vctg_pos_t t;
    g = 2'h0;
    p = 2'h0;
    par = 1'b0;
    k_on = 1'b0;
    t = 13'h0000;
    for (int o = 0; o < `VCTG_NUM_OUT; o++) begin
      g = concat ? 2'h0 : sq_gsel[2*o +: 2];
      par = 1'b0;
      for (int k = 0; k < 4; k++) begin
        k_on = !sq_gate[o] ||
               (sq_ctrl[`VCTG_F_PAIRSEL] == (k >= 2));
        for (int q = 0; q < 4; q++) begin
          p = sq_patsel[5*q +: 2];
          t = tog_mem[tog_idx(p, 5'(o), 2'(k))];
          if (k_on && (concat || 2'(q) == sq_gsel[2*o +: 2]) &&
              g_pos[g] >= t) begin
            par = ~par;
          end
        end
      end
      if (state == vctg_pkg::VCTG_IDLE) begin
        next_out[o] = 1'b0;
      end else if (hld[g]) begin
        next_out[o] = vertical_transfer_outputs[o];
      end else begin
        next_out[o] = sq_pol[o] ^ (g_act[g] & par);
      end
    end
  end

  // Outputs and line sync straight from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vertical_transfer_outputs <= 24'h000000;
      line_sync_n <= 1'b1;
    end else begin
      vertical_transfer_outputs <= next_out;
      line_sync_n <= ~((state == vctg_pkg::VCTG_RUN) &&
                       (pix == 13'h0001));
    end
  end

endmodule : vctg_sequencer
`default_nettype wire

//--- test/vctg_sequencer_assertions.sv
// Port-level checks of the vertical sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vctg_regs.svh"
module vctg_sequencer_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [23:0] vertical_transfer_outputs,
  input wire logic line_sync_n
);
  // ****************************************
  // Helper state
  // ****************************************
  localparam logic [11:0] HOLE_ADDR = 12'hFFC;
  logic run_q;
  logic [13:0] gap_cnt;
  // Run bit as committed by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (psel && penable && pready && pwrite &&
                 paddr == `VCTG_CTRL_ADDR) begin
      run_q <= pwdata[`VCTG_F_RUN];
    end
  end
  // Cycles since the last line start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 14'h0;
    end else if (!line_sync_n || !run_q) begin
      gap_cnt <= 14'h0;
    end else if (gap_cnt != 14'h3FFF) begin
      gap_cnt <= gap_cnt + 14'h1;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_zero_wait;
    s_setup |=> s_access;
  endproperty
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  property p_ready_single;
    s_access |=> !pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_status_ro;
    s_setup ##0 (pwrite && paddr == `VCTG_STAT_ADDR) |=> pslverr;
  endproperty
  property p_hole_read;
    s_setup ##0 (!pwrite && paddr == HOLE_ADDR) |=>
      pslverr && prdata == 32'h0;
  endproperty
  property p_rdata_hold;
    !pready |-> $stable(prdata);
  endproperty
  property p_sync_pulse;
    !line_sync_n |=> line_sync_n;
  endproperty
  property p_idle_quiet;
    !run_q && !$past(run_q) && !$past(run_q, 2) |->
      vertical_transfer_outputs == 24'h0 && line_sync_n;
  endproperty
  property p_line_bound;
    gap_cnt <= 14'h2000;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("no answer in access cycle");
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("ready outside access");
  a_ready_single: assert property (p_ready_single)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error without ready");
  a_status_ro: assert property (p_status_ro)
    else $error("status write accepted");
  a_hole_read: assert property (p_hole_read)
    else $error("unmapped read not refused");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved while idle");
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("line sync low too long");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("outputs active while stopped");
  a_line_bound: assert property (p_line_bound)
    else $error("line longer than allowed");
endmodule : vctg_sequencer_assertions
`default_nettype wire

//--- test/vctg_ccd_model.sv
// Sensor-side monitor: line periods and output edge offsets
`timescale 1ns/1ps
`default_nettype none
module vctg_ccd_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [23:0] vertical_transfer_outputs,
  input wire logic line_sync_n
);
  int cnt;
  int fall;
  int nline;
  int periods[$];
  int edges[$];
  logic prev_sync;
  logic [23:0] prev_out;
  // Stamp line starts and level changes of outputs 0 and 2
  always @(posedge pclk) begin
    if (!presetn) begin
      cnt = 0;
      fall = 0;
      nline = 0;
      prev_sync = 1'b1;
      prev_out = 24'h0;
    end else begin
      cnt++;
      if (prev_sync && !line_sync_n) begin
        if (nline > 0) begin
          periods.push_back(cnt - fall);
        end
        fall = cnt;
        nline++;
      end
      for (int i = 0; i < 3; i += 2) begin
        if (nline > 0 && vertical_transfer_outputs[i] !== prev_out[i]) begin
          edges.push_back((nline - 1) * 100000 + i * 10000 + cnt - fall);
        end
      end
      prev_sync = line_sync_n;
      prev_out = vertical_transfer_outputs;
    end
  end
endmodule : vctg_ccd_model
`default_nettype wire

//--- test/vertical_ccd_timing_sequencer_test.sv
// Self-checking bench for the vertical sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module vertical_ccd_timing_sequencer_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [23:0] vertical_transfer_outputs;
  logic line_sync_n;
  int fail_count, tests_run, n, li, reps;
  int exp_e[$], got_e[$], exp_p[$];
  logic [11:0] cfg_a [19] = '{12'h800, 12'h804, 12'h808, 12'h80C,
    12'h818, 12'h81C, 12'h828, 12'h82C, 12'h838, 12'h83C, 12'h840,
    12'h844, 12'hA00, 12'hA04, 12'hA08, 12'h000, 12'h004, 12'h1A0,
    12'h1A4};
  logic [31:0] cfg_d [19] = '{32'h20, 32'h100, 32'hA, 32'h28, 32'h1E,
    32'h14, 32'h2, 32'h1, 32'h20001, 32'h500064, 32'h2, 32'h10,
    32'h460001, 32'h4, 32'h0, 32'h5, 32'h14, 32'h3, 32'h8};
  vctg_sequencer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .vertical_transfer_outputs(vertical_transfer_outputs),
    .line_sync_n(line_sync_n));
  vctg_ccd_model u_ccd (
    .pclk(pclk), .presetn(presetn),
    .vertical_transfer_outputs(vertical_transfer_outputs),
    .line_sync_n(line_sync_n));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // One APB transfer; answer left in rd and er
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      fail_count++;
      final_report();
    end
  endtask : apb
  // Clock
  always #12.5 pclk = ~pclk;
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    void'($urandom(20));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and refusals
    for (int i = 0; i < 3; i++) begin
      apb(12'hC00 + 12'(i * 4), 1'b0, 32'h0);
      `CHK("reset word", 32'h0, rd)
      `CHK("reset err", 1'b0, er)
    end
    apb(12'hFFC, 1'b0, 32'h0);
    `CHK("hole err", 1'b1, er)
    apb(12'hC08, 1'b1, 32'hFFFF_FFFF);
    `CHK("status err", 1'b1, er)
    $display("test reset done");
    // Random readback of a spare sequence and toggle words
    for (int i = 0; i < 24; i++) begin
      d = $urandom;
      apb(12'h880 + 12'(i * 4), 1'b1, d);
      apb(12'h880 + 12'(i * 4), 1'b0, 32'h0);
      `CHK("seq word", d, rd)
      d = (i == 0) ? 32'h1FFF : ($urandom & 32'h1FFF);
      apb(12'h5F0 + 12'((i % 4) * 4), 1'b1, d);
      apb(12'h5F0 + 12'((i % 4) * 4), 1'b0, 32'h0);
      `CHK("toggle word", d[12:0], rd[12:0])
    end
    $display("test readback done");
    // Unused toggles to the maximum, then the pattern set
    for (int i = 0; i < 384; i++) begin
      apb(12'(i * 4), 1'b1, 32'h1FFF);
    end
    for (int i = 0; i < 19; i++) begin
      apb(cfg_a[i], 1'b1, cfg_d[i]);
      apb(cfg_a[i], 1'b0, 32'h0);
      `CHK("cfg word", cfg_d[i], rd)
    end
    apb(12'hC00, 1'b1, 32'h1);
    n = 0;
    while (u_ccd.nline < 9 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      final_report();
    end
    // Expected edges and periods over two passes of the field
    for (int l = 0; l < 8; l++) begin
      li = l % 4;
      reps = (li % 2 == 0) ? 2 : 1;
      for (int r = 0; r < reps; r++) begin
        exp_e.push_back(l * 100000 + 10 + 30 * r + 5);
        exp_e.push_back(l * 100000 + 10 + 30 * r + 20);
      end
      exp_e.push_back(l * 100000 + 20000 + 43);
      exp_e.push_back(l * 100000 + 20000 + 48);
      exp_p.push_back(li == 3 ? 70 : ((li % 2) ? 80 : 100));
    end
    foreach (u_ccd.edges[i]) begin
      if (u_ccd.edges[i] < 800000) begin
        got_e.push_back(u_ccd.edges[i]);
      end
    end
    exp_e.sort();
    got_e.sort();
    `CHK("edge count", exp_e.size(), got_e.size())
    for (int i = 0; i < exp_e.size() && i < got_e.size(); i++) begin
      `CHK("edge", exp_e[i], got_e[i])
    end
    for (int i = 0; i < 7; i++) begin
      `CHK("period", exp_p[i], u_ccd.periods[i])
    end
    `CHK("start level", 1'b1, vertical_transfer_outputs[1])
    apb(12'hC08, 1'b0, 32'h0);
    `CHK("running", 1'b1, rd[18])
    $display("test pattern done");
    // Stop and check quiet outputs
    apb(12'hC00, 1'b1, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK("idle outputs", 24'h0, vertical_transfer_outputs)
    $display("test stop done");
    // Hold window on even lines keeps every group's levels
    apb(12'h804, 1'b1, 32'h1010F);
    apb(12'h850, 1'b1, 32'h32000C);
    u_ccd.edges.delete();
    got_e.delete();
    li = u_ccd.nline;
    apb(12'hC00, 1'b1, 32'h1);
    n = 0;
    while (u_ccd.nline < li + 3 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 1000) begin
      fail_count++;
      final_report();
    end
    exp_e = '{li * 100000 + 49, li * 100000 + 60, li * 100000 + 100015,
      li * 100000 + 100030, li * 100000 + 120043, li * 100000 + 120048};
    foreach (u_ccd.edges[i]) begin
      if (u_ccd.edges[i] < (li + 2) * 100000) begin
        got_e.push_back(u_ccd.edges[i]);
      end
    end
    got_e.sort();
    `CHK("hold count", exp_e.size(), got_e.size())
    for (int i = 0; i < exp_e.size() && i < got_e.size(); i++) begin
      `CHK("hold edge", exp_e[i], got_e[i])
    end
    $display("test hold done");
    final_report();
  end
endmodule : vertical_ccd_timing_sequencer_test
bind vctg_sequencer vctg_sequencer_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .vertical_transfer_outputs(vertical_transfer_outputs),
  .line_sync_n(line_sync_n));
`default_nettype wire
